// ===== verilog/lviaw_top.sv
// Purpose: Low-voltage interrupt, common interrupt entry and return, and wake-up logic.
// Assumes: Single system clock; detector and edge pins are asynchronous to it.
// Notes: A request pin held high while the clock is stopped sets its flag once the clock runs again.
`timescale 1ns/10ps

module lviaw_flag (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic hw_set,
    input wire logic hw_clr,
    input wire logic sw_set,
    input wire logic sw_clr,
    output logic flag_q,
    output logic rise
);
    logic flag_d;

    // A set in the same cycle as any clear wins, so no event is lost.
    always_comb begin
        flag_d = (flag_q & ~hw_clr & ~sw_clr) | hw_set | sw_set;
        rise = flag_d & ~flag_q;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= lviaw_pkg::FLAG_RST;
        end else if (clk_en) begin
            flag_q <= flag_d;
        end
    end
endmodule

module lviaw_sync (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic pin,
    output logic level_q,
    output logic rise
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_d;

    // A change counts only once the second and third stages agree.
    always_comb begin
        level_d = (s2_q == s3_q) ? s3_q : level_q;
        rise = level_d & ~level_q;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= lviaw_pkg::SYNC_RST;
            s2_q <= lviaw_pkg::SYNC_RST;
            s3_q <= lviaw_pkg::SYNC_RST;
            level_q <= lviaw_pkg::SYNC_RST;
        end else if (clk_en) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end
endmodule

module lviaw_top (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic supply_drop_detector,
    input wire logic ext_edge_pin,
    input wire logic [lviaw_pkg::GRP_N-1:0] grp_src_evt,
    input wire logic [lviaw_pkg::GRP_N-1:0] grp_src_en,
    input wire logic low_voltage_irq_enable,
    input wire logic ext_irq_enable,
    input wire logic grp_irq_enable,
    input wire logic sw_glb_en_set,
    input wire logic sw_glb_en_clr,
    input wire logic sw_lv_flag_set,
    input wire logic sw_lv_flag_clr,
    input wire logic sw_ext_flag_set,
    input wire logic sw_ext_flag_clr,
    input wire logic sw_grp_flag_set,
    input wire logic sw_grp_flag_clr,
    input wire logic [lviaw_pkg::GRP_N-1:0] sw_src_flag_clr,
    input wire logic stack_full,
    input wire logic instr_boundary,
    input wire logic sleep_mode,
    input wire logic plain_return,
    input wire logic return_and_reenable,
    output logic global_irq_enable,
    output logic low_voltage_request_flag,
    output logic ext_request_flag,
    output logic grouped_request_flag,
    output logic [lviaw_pkg::GRP_N-1:0] src_request_flag,
    output logic vec_call,
    output lviaw_pkg::lviaw_vec_t vec_id,
    output logic push_pc,
    output logic pop_pc,
    output logic seq_busy,
    output logic wake_up,
    output logic lv_wake_async
);
    logic lv_rise_evt;
    logic ext_rise_evt;
    logic lv_level;
    logic lv_flag_rise;
    logic ext_flag_rise;
    logic grp_flag_rise;
    logic [lviaw_pkg::GRP_N-1:0] src_flag_rise;
    logic take;
    lviaw_pkg::lviaw_vec_t sel;
    logic clr_lv;
    logic clr_ext;
    logic clr_grp;
    logic grp_hw_set;

    // Pins from outside the clock domain.
    lviaw_sync u_sync_lv (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .pin(supply_drop_detector),
        .level_q(lv_level),
        .rise(lv_rise_evt)
    );

    lviaw_sync u_sync_ext (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .pin(ext_edge_pin),
        .level_q(),
        .rise(ext_rise_evt)
    );

    // While the oscillator is stopped no edge is seen on the synchroniser, so the
    // detector level is offered straight to the clock controller to restart it.
    // The flag itself then sets from the held level on the first clocks back.
    assign lv_wake_async = sleep_mode & supply_drop_detector & ~lv_level;

    lviaw_flag u_flag_lv (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .hw_set(lv_rise_evt),
        .hw_clr(clr_lv),
        .sw_set(sw_lv_flag_set),
        .sw_clr(sw_lv_flag_clr),
        .flag_q(low_voltage_request_flag),
        .rise(lv_flag_rise)
    );

    lviaw_flag u_flag_ext (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .hw_set(ext_rise_evt),
        .hw_clr(clr_ext),
        .sw_set(sw_ext_flag_set),
        .sw_clr(sw_ext_flag_clr),
        .flag_q(ext_request_flag),
        .rise(ext_flag_rise)
    );

    // Original source flags are cleared by software only, never by servicing.
    for (genvar i = 0; i < lviaw_pkg::GRP_N; i++) begin : g_src
        lviaw_flag u_flag_src (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .clk_en(clk_en),
            .hw_set(grp_src_evt[i] & grp_src_en[i]),
            .hw_clr(1'h0),
            .sw_set(1'h0),
            .sw_clr(sw_src_flag_clr[i]),
            .flag_q(src_request_flag[i]),
            .rise(src_flag_rise[i])
        );
    end

    assign grp_hw_set = |(grp_src_evt & grp_src_en);

    lviaw_flag u_flag_grp (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .hw_set(grp_hw_set),
        .hw_clr(clr_grp),
        .sw_set(sw_grp_flag_set),
        .sw_clr(sw_grp_flag_clr),
        .flag_q(grouped_request_flag),
        .rise(grp_flag_rise)
    );

    // Wake-up group: any flag rising, whatever its enable.
    logic wake_d;

    always_comb begin
        wake_d = sleep_mode
            & (lv_flag_rise | ext_flag_rise | grp_flag_rise | (|src_flag_rise));
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wake_up <= lviaw_pkg::PULSE_RST;
        end else if (clk_en) begin
            wake_up <= wake_d;
        end
    end

    // Source selection, fixed priority: supply first, then edge pin, then group.
    always_comb begin
        sel = lviaw_pkg::VEC_NONE;
        if (low_voltage_request_flag && low_voltage_irq_enable) begin
            sel = lviaw_pkg::VEC_LV;
        end else if (ext_request_flag && ext_irq_enable) begin
            sel = lviaw_pkg::VEC_EXT;
        end else if (grouped_request_flag && grp_irq_enable) begin
            sel = lviaw_pkg::VEC_GRP;
        end
    end

    // Sequencer group: entry, return and global enable.
    lviaw_pkg::lviaw_state_t state_q;
    lviaw_pkg::lviaw_state_t state_d;
    logic [lviaw_pkg::CNT_W-1:0] cnt_q;
    logic [lviaw_pkg::CNT_W-1:0] cnt_d;
    logic reen_q;
    logic reen_d;
    logic glb_en_q;
    logic glb_en_d;
    logic vec_call_d;
    logic push_pc_d;
    logic pop_pc_d;
    lviaw_pkg::lviaw_vec_t vec_id_d;

    // A full stack simply withholds the take; the flag stays set and the
    // request is reconsidered at every later boundary.
    assign take = (state_q == lviaw_pkg::ST_RUN) && instr_boundary && !sleep_mode
        && glb_en_q && !stack_full && (sel != lviaw_pkg::VEC_NONE)
        && !plain_return && !return_and_reenable;
    assign clr_lv = take && (sel == lviaw_pkg::VEC_LV);
    assign clr_ext = take && (sel == lviaw_pkg::VEC_EXT);
    assign clr_grp = take && (sel == lviaw_pkg::VEC_GRP);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        reen_d = reen_q;
        glb_en_d = glb_en_q;
        vec_call_d = 1'h0;
        push_pc_d = 1'h0;
        pop_pc_d = 1'h0;
        vec_id_d = vec_id;
        if (sw_glb_en_clr) begin
            glb_en_d = 1'h0;
        end
        if (sw_glb_en_set) begin
            glb_en_d = 1'h1;
        end
        case (state_q)
            lviaw_pkg::ST_RUN: begin
                if (plain_return || return_and_reenable) begin
                    state_d = lviaw_pkg::ST_RETURN;
                    cnt_d = lviaw_pkg::CNT_ZERO;
                    reen_d = return_and_reenable;
                end else if (take) begin
                    state_d = lviaw_pkg::ST_ENTRY;
                    cnt_d = lviaw_pkg::CNT_ZERO;
                    vec_call_d = 1'h1;
                    push_pc_d = 1'h1;
                    vec_id_d = sel;
                end
            end
            lviaw_pkg::ST_ENTRY: begin
                cnt_d = cnt_q + lviaw_pkg::CNT_ONE;
                if (cnt_q == lviaw_pkg::CALL_LAST) begin
                    state_d = lviaw_pkg::ST_RUN;
                end
            end
            lviaw_pkg::ST_RETURN: begin
                cnt_d = cnt_q + lviaw_pkg::CNT_ONE;
                if (cnt_q == lviaw_pkg::RTN_LAST) begin
                    state_d = lviaw_pkg::ST_RUN;
                    pop_pc_d = 1'h1;
                    if (reen_q) begin
                        glb_en_d = 1'h1;
                    end
                end
            end
            default: begin
                state_d = lviaw_pkg::ST_RUN;
            end
        endcase
        // Service clears last so that no second source can slip in behind it.
        if (take) begin
            glb_en_d = 1'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= lviaw_pkg::ST_RUN;
            cnt_q <= lviaw_pkg::CNT_ZERO;
            reen_q <= lviaw_pkg::PULSE_RST;
            glb_en_q <= lviaw_pkg::GLB_EN_RST;
            vec_call <= lviaw_pkg::PULSE_RST;
            push_pc <= lviaw_pkg::PULSE_RST;
            pop_pc <= lviaw_pkg::PULSE_RST;
            vec_id <= lviaw_pkg::VEC_NONE;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            reen_q <= reen_d;
            glb_en_q <= glb_en_d;
            vec_call <= vec_call_d;
            push_pc <= push_pc_d;
            pop_pc <= pop_pc_d;
            vec_id <= vec_id_d;
        end
    end

    assign global_irq_enable = glb_en_q;
    assign seq_busy = (state_q != lviaw_pkg::ST_RUN);

endmodule

// ===== verilog/lviaw_pkg.sv
// Purpose: Shared constants and types for the low-voltage interrupt and wake-up block.
// Assumes: System clock of 10 MHz; four system clocks form one instruction cycle.
// Notes: Source count of the grouped request is fixed here and used by the bench too.
package lviaw_pkg;

    // System clock rate and instruction timing.
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned SYSCLK_PER_ICYC = 4;
    localparam int unsigned RTN_ICYC = 2;
    localparam int unsigned CALL_ICYC = 2;
    localparam int unsigned RTN_CLKS = RTN_ICYC * SYSCLK_PER_ICYC;
    localparam int unsigned CALL_CLKS = CALL_ICYC * SYSCLK_PER_ICYC;

    // Sequence counter, wide enough for the longest sequence.
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
    localparam logic [CNT_W-1:0] RTN_LAST = CNT_W'(RTN_CLKS - 1);
    localparam logic [CNT_W-1:0] CALL_LAST = CNT_W'(CALL_CLKS - 1);

    // Number of original sources merged into the grouped request.
    localparam int GRP_N = 4;

    // Reset values.
    localparam logic FLAG_RST = 1'h0;
    localparam logic GLB_EN_RST = 1'h0;
    localparam logic PULSE_RST = 1'h0;
    localparam logic SYNC_RST = 1'h0;

    // Vector selected on entry; codes double as the priority order, low first.
    typedef enum logic [1:0] {
        VEC_NONE = 2'b00,
        VEC_LV = 2'b01,
        VEC_EXT = 2'b10,
        VEC_GRP = 2'b11
    } lviaw_vec_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_ENTRY = 2'b01,
        ST_RETURN = 2'b10
    } lviaw_state_t;

endpackage

// ===== testbench/lviaw_top_monitor.sv
// Purpose: Port-level checks for the low-voltage interrupt and wake-up block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound into the top module; it watches design outputs and some of its inputs.
`timescale 1ns/10ps
module lviaw_top_monitor (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic low_voltage_irq_enable,
    input wire logic sw_lv_flag_clr,
    input wire logic [lviaw_pkg::GRP_N-1:0] sw_src_flag_clr,
    input wire logic stack_full,
    input wire logic instr_boundary,
    input wire logic sleep_mode,
    input wire logic plain_return,
    input wire logic return_and_reenable,
    input wire logic global_irq_enable,
    input wire logic low_voltage_request_flag,
    input wire logic ext_request_flag,
    input wire logic grouped_request_flag,
    input wire logic [lviaw_pkg::GRP_N-1:0] src_request_flag,
    input wire logic vec_call,
    input wire lviaw_pkg::lviaw_vec_t vec_id,
    input wire logic push_pc,
    input wire logic pop_pc,
    input wire logic seq_busy,
    input wire logic wake_up
);
    logic [lviaw_pkg::GRP_N+2:0] all_f;
    assign all_f = {low_voltage_request_flag, ext_request_flag, grouped_request_flag,
        src_request_flag};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    entry_gate_a: assert property (vec_call |-> $past(global_irq_enable)
        && !$past(stack_full) && !$past(sleep_mode) && $past(instr_boundary))
        else $error("entry taken without its conditions");
    lv_enable_a: assert property (vec_call && vec_id == lviaw_pkg::VEC_LV
        |-> $past(low_voltage_irq_enable)) else $error("low-voltage entry while disabled");
    push_only_a: assert property (push_pc == vec_call)
        else $error("push not paired with entry");
    entry_clear_a: assert property (vec_call |-> !global_irq_enable)
        else $error("global enable left set on entry");
    lv_hold_a: assert property ($fell(low_voltage_request_flag) |-> $past(sw_lv_flag_clr)
        || (vec_call && vec_id == lviaw_pkg::VEC_LV)) else $error("low-voltage flag lost");
    src_hold_a: assert property ((($past(src_request_flag) & ~src_request_flag)
        & ~$past(sw_src_flag_clr)) == '0) else $error("source flag cleared by hardware");
    wake_cause_a: assert property (wake_up |-> $past(sleep_mode)
        && (all_f & ~$past(all_f)) != '0) else $error("wake without a rising flag");
    busy_len_a: assert property ($rose(seq_busy) |-> seq_busy[*8] ##1 !seq_busy)
        else $error("sequence length wrong");
    rtn_time_a: assert property ((plain_return || return_and_reenable)
        && !seq_busy && clk_en |=> !pop_pc[*8] ##1 pop_pc) else $error("pop not at eighth clock");
    reen_enable_a: assert property (return_and_reenable && !seq_busy && clk_en
        |-> ##9 global_irq_enable) else $error("global enable not restored");
endmodule

bind lviaw_top lviaw_top_monitor u_mon (.clk_sys, .rst_b, .clk_en, .low_voltage_irq_enable,
    .sw_lv_flag_clr, .sw_src_flag_clr, .stack_full, .instr_boundary, .sleep_mode,
    .plain_return, .return_and_reenable, .global_irq_enable, .low_voltage_request_flag,
    .ext_request_flag, .grouped_request_flag, .src_request_flag, .vec_call, .vec_id,
    .push_pc, .pop_pc, .seq_busy, .wake_up);

// ===== testbench/lviaw_core_model.sv
// Purpose: Program sequencer and stack of the core beside the interrupt block.
// Assumes: Four system clocks to an instruction cycle.
// Notes: A small stack depth lets the bench reach the full-stack case quickly.
`timescale 1ns/10ps
module lviaw_core_model #(
    parameter int DEPTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic push_pc,
    input wire logic pop_pc,
    output logic instr_boundary,
    output logic stack_full
);
    logic [1:0] phase_q;
    int depth_q;
    // One slot per entry: only the return address is stacked, never other state.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= 2'h0;
            depth_q <= 0;
        end else begin
            phase_q <= phase_q + 2'h1;
            depth_q <= depth_q + int'(push_pc) - int'(pop_pc);
        end
    end
    assign instr_boundary = (phase_q == 2'h3);
    assign stack_full = (depth_q >= DEPTH);
endmodule

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the low-voltage interrupt and wake-up block.
// Assumes: Stack depth of one in the core model.
// Notes: Inputs change one nanosecond after each rising clock edge.
`timescale 1ns/10ps
module tb_top;
    logic clk_sys = 1'h0;
    logic rst_b = 1'h0;
    logic clk_en, supply_drop_detector, ext_edge_pin, low_voltage_irq_enable, ext_irq_enable;
    logic grp_irq_enable, sw_glb_en_set, sw_glb_en_clr, sw_lv_flag_set, sw_lv_flag_clr;
    logic sw_ext_flag_set, sw_ext_flag_clr, sw_grp_flag_set, sw_grp_flag_clr, stack_full;
    logic instr_boundary, sleep_mode, plain_return, return_and_reenable;
    logic [3:0] grp_src_evt, grp_src_en, sw_src_flag_clr, src_request_flag;
    logic global_irq_enable, low_voltage_request_flag, ext_request_flag, grouped_request_flag;
    logic vec_call, push_pc, pop_pc, seq_busy, wake_up, lv_wake_async;
    lviaw_pkg::lviaw_vec_t vec_id;
    int num_errors = 0;
    int checks_done = 0;

    lviaw_top uut (.clk_sys, .rst_b, .clk_en, .supply_drop_detector, .ext_edge_pin,
        .grp_src_evt, .grp_src_en, .low_voltage_irq_enable, .ext_irq_enable, .grp_irq_enable,
        .sw_glb_en_set, .sw_glb_en_clr, .sw_lv_flag_set, .sw_lv_flag_clr, .sw_ext_flag_set,
        .sw_ext_flag_clr, .sw_grp_flag_set, .sw_grp_flag_clr, .sw_src_flag_clr, .stack_full,
        .instr_boundary, .sleep_mode, .plain_return, .return_and_reenable, .global_irq_enable,
        .low_voltage_request_flag, .ext_request_flag, .grouped_request_flag, .src_request_flag,
        .vec_call, .vec_id, .push_pc, .pop_pc, .seq_busy, .wake_up, .lv_wake_async);
    lviaw_core_model #(.DEPTH(1)) u_core (.clk_sys, .rst_b, .push_pc, .pop_pc,
        .instr_boundary, .stack_full);

    always #50 clk_sys = ~clk_sys;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic seen, input logic exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_hi(input logic wake);
        int n;
        n = 0;
        while (n < 12 && (wake ? wake_up : vec_call) !== 1'h1) begin
            cyc(1);
            n++;
        end
        chk(wake ? wake_up : vec_call, 1'h1);
    endtask
    task automatic do_rtn(input logic reen);
        plain_return = !reen;
        return_and_reenable = reen;
        cyc(1);
        plain_return = 1'h0;
        return_and_reenable = 1'h0;
        cyc(7);
        chk(pop_pc, 1'h0);
        cyc(1);
        chk(pop_pc, 1'h1);
        chk(global_irq_enable, reen);
        cyc(1);
    endtask
    task automatic pulse_glb_en;
        sw_glb_en_set = 1'h1;
        cyc(1);
        sw_glb_en_set = 1'h0;
    endtask

    task automatic t_lv_entry;
        supply_drop_detector = 1'h1;
        pulse_glb_en();
        cyc(12);
        chk(low_voltage_request_flag, 1'h1);
        low_voltage_irq_enable = 1'h1;
        supply_drop_detector = 1'h0;
        wait_hi(1'h0);
        chk(vec_id == lviaw_pkg::VEC_LV, 1'h1);
        chk(push_pc, 1'h1);
        chk(low_voltage_request_flag, 1'h0);
        chk(global_irq_enable, 1'h0);
        cyc(10);
    endtask
    task automatic t_stack_full;
        ext_irq_enable = 1'h1;
        ext_edge_pin = 1'h1;
        pulse_glb_en();
        cyc(12);
        chk(ext_request_flag, 1'h1);
        sw_glb_en_clr = 1'h1;
        cyc(1);
        sw_glb_en_clr = 1'h0;
        chk(global_irq_enable, 1'h0);
        do_rtn(1'h1);
        wait_hi(1'h0);
        chk(vec_id == lviaw_pkg::VEC_EXT, 1'h1);
        ext_edge_pin = 1'h0;
        cyc(10);
        do_rtn(1'h0);
    endtask
    task automatic t_grp;
        grp_src_en = 4'hF;
        grp_irq_enable = 1'h1;
        grp_src_evt = 4'h4;
        pulse_glb_en();
        grp_src_evt = 4'h0;
        wait_hi(1'h0);
        chk(vec_id == lviaw_pkg::VEC_GRP, 1'h1);
        chk(grouped_request_flag, 1'h0);
        chk(src_request_flag[2], 1'h1);
        sw_src_flag_clr = 4'h4;
        cyc(1);
        sw_src_flag_clr = 4'h0;
        cyc(1);
        chk(src_request_flag[2], 1'h0);
        cyc(8);
        do_rtn(1'h0);
    endtask
    task automatic t_wake;
        sleep_mode = 1'h1;
        ext_irq_enable = 1'h0;
        sw_ext_flag_set = 1'h1;
        cyc(1);
        sw_ext_flag_set = 1'h0;
        chk(wake_up, 1'h1);
        cyc(1);
        sw_ext_flag_set = 1'h1;
        cyc(1);
        sw_ext_flag_set = 1'h0;
        chk(wake_up, 1'h0);
        clk_en = 1'h0;
        supply_drop_detector = 1'h1;
        cyc(3);
        chk(lv_wake_async, 1'h1);
        clk_en = 1'h1;
        wait_hi(1'h1);
        chk(low_voltage_request_flag, 1'h1);
        sleep_mode = 1'h0;
    endtask
    task automatic t_sw;
        {sw_lv_flag_clr, sw_ext_flag_clr, sw_grp_flag_set} = 3'h7;
        cyc(1);
        {sw_lv_flag_clr, sw_ext_flag_clr, sw_grp_flag_set} = 3'h0;
        chk(low_voltage_request_flag, 1'h0);
        chk(ext_request_flag, 1'h0);
        chk(grouped_request_flag, 1'h1);
        {sw_grp_flag_clr, sw_lv_flag_set, sw_ext_flag_set, sw_ext_flag_clr} = 4'hF;
        cyc(1);
        {sw_grp_flag_clr, sw_lv_flag_set, sw_ext_flag_set, sw_ext_flag_clr} = 4'h0;
        chk(grouped_request_flag, 1'h0);
        chk(low_voltage_request_flag, 1'h1);
        chk(ext_request_flag, 1'h1);
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        {supply_drop_detector, ext_edge_pin, low_voltage_irq_enable, ext_irq_enable} = '0;
        {grp_irq_enable, sw_glb_en_set, sw_glb_en_clr, sw_lv_flag_set, sw_lv_flag_clr} = '0;
        {sw_ext_flag_set, sw_ext_flag_clr, sw_grp_flag_set, sw_grp_flag_clr} = '0;
        {sleep_mode, plain_return, return_and_reenable} = '0;
        {grp_src_evt, grp_src_en, sw_src_flag_clr} = '0;
        clk_en = 1'h1;
        cyc(12);
        rst_b = 1'h1;
        cyc(2);
        t_lv_entry();
        t_stack_full();
        t_grp();
        t_wake();
        t_sw();
        end_sim();
    end
    initial begin
        #100000;
        num_errors++;
        end_sim();
    end
endmodule
